//--- silc_host.sv
// Host end of the serial interrupt line, with LPC clock outputs and clock-run control.
// Assumes an APB master on pclk and peripherals reached through silc_if.
`timescale 1ns/10ps
`include "silc_defs.svh"

module silc_host
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        deep_idle,
  input  wire logic [15:0] internal_irq_n,
  input  wire logic        chan_chk_in_n,
  input  wire logic [3:0]  pcie_shared_irq_inputs,
  input  wire logic        loopback_select_strap,
  input  wire logic        second_clock_enable_strap,
  output logic      [15:0] isa_irq_n,
  output logic      [3:0]  pci_irq_n,
  output logic             sys_mgmt_interrupt_n,
  output logic             channel_check_error_n,
  output logic             lpc_clk1_out,
  silc_if.host             link
);
  import silc_pkg::*;

  localparam logic [20:0] IGNORED = `SILC_IGNORE_MASK;

  silc_host_s r;
  silc_host_s n;
  logic [7:0] sy;
  logic [4:0] fi;
  logic       en;
  logic       tick;
  logic       smp;
  logic       crl;
  logic       setup;
  logic       wr;
  logic       busy;

  silc_sync #(.W(8)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({pcie_shared_irq_inputs, loopback_select_strap, second_clock_enable_strap,
               link.ser_line, link.clk_run_line}),
    .q       (sy)
  );

  always_comb
  begin
    n         = r;
    smp       = sy[1];
    crl       = sy[0];
    fi        = 5'(r.fr - 5'h1);
    en        = r.ctrl[`SILC_CTRL_SIRQ_EN] & ~deep_idle;
    busy      = (r.st != HS_IDLE) && (r.st != HS_QUIET);
    tick      = 1'b0;
    setup     = psel & ~penable;
    wr        = psel & penable & r.pready & pwrite;
    n.pready  = setup;
    n.pslverr = 1'b0;

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    // Read data is captured in the setup cycle so that every output stays a flop.
    if (setup)
    begin
      if (paddr == `SILC_OFF_CTRL)
        n.prdata = {27'h000_0000, r.ctrl};
      else if (paddr == `SILC_OFF_STAT)
        n.prdata = {26'h000_0000, r.cr == CR_STOPPED, r.ctrl[`SILC_CTRL_CLK1_EN], r.loop,
                    busy, r.quiet, r.flag};
      else if (paddr == `SILC_OFF_DEC)
        n.prdata = {11'h000, r.dec};
      else
      begin
        n.prdata  = 32'h0000_0000;
        n.pslverr = 1'b1;
      end
    end
    if (wr && paddr == `SILC_OFF_CTRL)
    begin
      n.ctrl                     = pwdata[4:0];
      n.ctrl[`SILC_CTRL_CLK1_EN] = pwdata[`SILC_CTRL_CLK1_EN] & ~r.loop;
    end
    else if (wr && paddr == `SILC_OFF_STAT && pwdata[`SILC_STAT_FLAG])
      n.flag = 1'b0;

    // Straps are taken once, after the synchroniser has filled.
    if (!r.strap_done)
    begin
      n.settle = r.settle + 2'h1;
      if (r.settle == `SILC_STRAP_SETTLE)
      begin
        n.strap_done               = 1'b1;
        n.loop                     = sy[3];
        n.ctrl[`SILC_CTRL_CLK1_EN] = sy[2] & ~sy[3];
      end
    end

    // ----------------------------------------------------------------
    // Link clock
    // ----------------------------------------------------------------
    // tick marks the pclk cycle that ends a link clock; the rise follows it.
    if (!deep_idle && r.cr != CR_STOPPED)
    begin
      if (r.div == 4'(`SILC_LPC_HALF - 1))
      begin
        n.div  = 4'h0;
        n.lclk = ~r.lclk;
        tick   = ~r.lclk & r.ctrl[`SILC_CTRL_CLK0_EN];
      end
      else
        n.div = r.div + 4'h1;
    end
    n.clk0 = n.lclk & r.ctrl[`SILC_CTRL_CLK0_EN] & ~deep_idle;
    n.clk1 = n.lclk & r.ctrl[`SILC_CTRL_CLK1_EN] & ~r.loop & ~deep_idle;

    // ----------------------------------------------------------------
    // Serial interrupt cycle
    // ----------------------------------------------------------------
    if (tick)
    begin
      case (r.st)
        HS_IDLE:
          if (en)
          begin
            n.st       = HS_START;
            n.len      = 4'(`SILC_START_CLKS - 1);
            n.ser_oe_n = 1'b0;
          end
        HS_QUIET:
          if (!en)
            n.st = HS_IDLE;
          else if (!smp)
          begin
            n.st       = HS_START;
            n.len      = 4'(`SILC_START_CLKS - 2);
            n.ser_oe_n = 1'b0;
          end
        HS_START:
          if (r.len == 4'h0)
          begin
            n.st       = HS_DATA;
            n.ph       = PH_TURN;
            n.fr       = 5'h0;
            n.ser_oe_n = 1'b1;
          end
          else
            n.len = r.len - 4'h1;
        HS_DATA:
        begin
          if (r.ph == PH_SAMPLE)
          begin
            n.dec[fi] = smp | IGNORED[fi];
            if (r.fr == `SILC_FR_SYS_MGMT && !smp)
              n.flag = 1'b1;
          end
          if (r.ph == PH_TURN)
          begin
            if (r.fr == `SILC_NFRAMES)
            begin
              n.st       = HS_STOP;
              n.ser_oe_n = 1'b0;
              n.quiet    = ~r.ctrl[`SILC_CTRL_STOP_W];
              n.len      = r.ctrl[`SILC_CTRL_STOP_W] ? 4'(`SILC_STOP_CONT - 1)
                                                     : 4'(`SILC_STOP_QUIET - 1);
            end
            else
            begin
              n.ph = PH_SAMPLE;
              n.fr = r.fr + 5'h1;
            end
          end
          else if (r.ph == PH_SAMPLE)
            n.ph = PH_RECOV;
          else
            n.ph = PH_TURN;
        end
        HS_STOP:
          if (r.len == 4'h0)
          begin
            n.st       = HS_RECOV;
            n.ser_oe_n = 1'b1;
          end
          else
            n.len = r.len - 4'h1;
        HS_RECOV:
          if (!en)
            n.st = HS_IDLE;
          else if (r.quiet)
            n.st = HS_QUIET;
          else
          begin
            n.st       = HS_START;
            n.len      = 4'(`SILC_START_CLKS - 1);
            n.ser_oe_n = 1'b0;
          end
        default:
          n.st = HS_IDLE;
      endcase
    end
    if (r.st == HS_IDLE)
      n.dec = `SILC_DEC_IDLE;
    if (deep_idle)
    begin
      n.st       = HS_IDLE;
      n.ser_oe_n = 1'b1;
    end

    // ----------------------------------------------------------------
    // Clock run
    // ----------------------------------------------------------------
    // The clock is only offered for stopping while the line is quiet; a peripheral
    // that pulls the clock-run line low at any time brings it back.
    case (r.cr)
      CR_RUN:
        if (tick && r.ctrl[`SILC_CTRL_CRUN_EN] && r.st == HS_QUIET && smp)
        begin
          n.cr      = CR_ASK;
          n.cr_oe_n = 1'b1;
          n.crcnt   = 3'(`SILC_CLK_RUN_WAIT - 1);
        end
      CR_ASK:
        if (!r.ctrl[`SILC_CTRL_CRUN_EN] || r.st != HS_QUIET || (tick && !crl))
        begin
          n.cr      = CR_RUN;
          n.cr_oe_n = 1'b0;
        end
        else if (tick)
        begin
          if (r.crcnt == 3'h0)
            n.cr = CR_STOPPED;
          else
            n.crcnt = r.crcnt - 3'h1;
        end
      CR_STOPPED:
        if (!r.ctrl[`SILC_CTRL_CRUN_EN] || !en || !crl)
        begin
          n.cr      = CR_RUN;
          n.cr_oe_n = 1'b0;
        end
      default:
        n.cr = CR_RUN;
    endcase

    // ----------------------------------------------------------------
    // Merged interrupt outputs
    // ----------------------------------------------------------------
    n.isa_n  = internal_irq_n & {r.dec[15:3], 1'b1, r.dec[1:0]};
    n.pci_n  = sy[7:4] & r.dec[20:17];
    n.mgmt_n = r.dec[`SILC_BIT_SYS_MGMT];
    n.chk_n  = r.dec[`SILC_BIT_CHAN_CHK] & chan_chk_in_n;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r          <= '0;
      r.ser_oe_n <= 1'b1;
      r.ctrl     <= `SILC_CTRL_RST;
      r.dec      <= `SILC_DEC_IDLE;
      r.isa_n    <= 16'hffff;
      r.pci_n    <= 4'hf;
      r.mgmt_n   <= 1'b1;
      r.chk_n    <= 1'b1;
    end
    else if (ce)
      r <= n;
  end

  assign prdata                 = r.prdata;
  assign pready                 = r.pready;
  assign pslverr                = r.pslverr;
  assign isa_irq_n              = r.isa_n;
  assign pci_irq_n              = r.pci_n;
  assign sys_mgmt_interrupt_n   = r.mgmt_n;
  assign channel_check_error_n  = r.chk_n;
  assign lpc_clk1_out           = r.clk1;
  assign link.lpc_clk           = r.clk0;
  assign link.ser_host_o        = 1'b0;
  assign link.ser_host_oe_n     = r.ser_oe_n;
  assign link.clk_run_host_o    = 1'b0;
  assign link.clk_run_host_oe_n = r.cr_oe_n;
endmodule // silc_host

//--- silc_defs.svh
// Constants of the serial interrupt host, its peripheral end and the LPC clock control.
// Assumes a 100 MHz pclk; the host makes the 80 ns link clock by dividing pclk.
//
// Function
// - Count data frames from start frame rising edge
// - Data frame: sample, recovery, turn-around, one clock
// - Peripheral drives low in sample when interrupt low
// - Peripheral drives high in recovery after low
// - Peripheral releases line in turn-around
// - Host drives stop frame two or three clocks
// - Two-clock stop quiet, three-clock stop continuous
// - Host decodes 21 frames at fixed offsets
// - Ignore frames of IRQ0, IRQ8, IRQ13, IRQ14
// - AND decoded PCI interrupts with shared inputs
// - AND other decoded interrupts with internal sources; the management frame output is not ANDed with any source
// - Low management frame raises interrupt, sets flag
// - Low channel-check frame acts as error signal
// - Deep idle disables LPC and serial interrupt
// - Serial interrupt off while enable bit zero
// - Loopback zero: clock one follows its strap
// - Loopback one: clock one forced disabled
// - Each LPC clock runs only when enabled
// - Clock run off after reset until enabled
// - Continuous mode start frame is 8 clocks
// - Quiet start: host completes one clock shorter
// - First cycle after enable is continuous
`ifndef SILC_DEFS_SVH
`define SILC_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SILC_PCLK_NS       10
`define SILC_LPC_PERIOD_NS 80
`define SILC_LPC_HALF      ((`SILC_LPC_PERIOD_NS / `SILC_PCLK_NS) / 2)
`define SILC_START_CLKS    8
`define SILC_STOP_QUIET    2
`define SILC_STOP_CONT     3
`define SILC_START_MIN     4
`define SILC_CLK_RUN_WAIT  4
`define SILC_STRAP_SETTLE  2'h3

// ----------------------------------------------------------------
// Frames
// ----------------------------------------------------------------
`define SILC_NFRAMES       5'h15
`define SILC_IGNORE_MASK   21'h0_6101
`define SILC_DEC_IDLE      21'h1f_ffff
`define SILC_FR_SYS_MGMT   5'h3
`define SILC_BIT_SYS_MGMT  2
`define SILC_BIT_CHAN_CHK  16

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
`define SILC_OFF_CTRL      12'h000
`define SILC_OFF_STAT      12'h004
`define SILC_OFF_DEC       12'h008
`define SILC_CTRL_SIRQ_EN  0
`define SILC_CTRL_STOP_W   1
`define SILC_CTRL_CRUN_EN  2
`define SILC_CTRL_CLK0_EN  3
`define SILC_CTRL_CLK1_EN  4
`define SILC_CTRL_RST      5'h0a
`define SILC_STAT_FLAG     0

`endif

//--- silc_pkg.sv
// Types shared by both ends of the serial interrupt link.
// Assumes silc_defs.svh for all numeric constants.
package silc_pkg;

  typedef enum logic [2:0] {HS_IDLE, HS_START, HS_DATA, HS_STOP, HS_RECOV, HS_QUIET} silc_hst_e;
  typedef enum logic [1:0] {CR_RUN, CR_ASK, CR_STOPPED} silc_crun_e;
  typedef enum logic [1:0] {PH_SAMPLE, PH_RECOV, PH_TURN} silc_phase_e;

  typedef struct packed {
    silc_hst_e   st;
    silc_phase_e ph;
    logic [4:0]  fr;
    logic [3:0]  len;
    logic        quiet;
    logic [3:0]  div;
    logic        lclk;
    logic        clk0;
    logic        clk1;
    silc_crun_e  cr;
    logic [2:0]  crcnt;
    logic        ser_oe_n;
    logic        cr_oe_n;
    logic [4:0]  ctrl;
    logic        flag;
    logic        loop;
    logic [1:0]  settle;
    logic        strap_done;
    logic [20:0] dec;
    logic [15:0] isa_n;
    logic [3:0]  pci_n;
    logic        mgmt_n;
    logic        chk_n;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } silc_host_s;

  typedef struct packed {
    logic        lprev;
    logic        act;
    silc_phase_e ph;
    logic [4:0]  fr;
    logic [3:0]  run;
    logic        quiet;
    logic        o;
    logic        oe_n;
    logic        cr_oe_n;
    logic [20:0] sent;
  } silc_per_s;

endpackage

//--- silc_if.sv
// Link between the host end and the peripheral end: clock, serial line, clock-run line.
// Both lines are pulled up; a party pulls low when its enable is low and its output low.
`timescale 1ns/10ps

interface silc_if;
  logic lpc_clk;
  logic ser_host_o;
  logic ser_host_oe_n;
  logic ser_dev_o;
  logic ser_dev_oe_n;
  logic ser_line;
  logic clk_run_host_o;
  logic clk_run_host_oe_n;
  logic clk_run_dev_o;
  logic clk_run_dev_oe_n;
  logic clk_run_line;

  assign ser_line     = (ser_host_oe_n | ser_host_o) & (ser_dev_oe_n | ser_dev_o);
  assign clk_run_line = (clk_run_host_oe_n | clk_run_host_o) & (clk_run_dev_oe_n | clk_run_dev_o);

  modport host (output lpc_clk, ser_host_o, ser_host_oe_n, clk_run_host_o, clk_run_host_oe_n,
                input  ser_line, clk_run_line);
  modport dev  (input  lpc_clk, ser_line, clk_run_line,
                output ser_dev_o, ser_dev_oe_n, clk_run_dev_o, clk_run_dev_oe_n);
endinterface

//--- silc_sync.sv
// Two-stage synchroniser for levels entering the pclk domain.
// Assumes idle-high inputs, so both stages reset to ones.
`timescale 1ns/10ps

module silc_sync
#(
  parameter int W = 1
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } silc_sync_s;

  silc_sync_s r;
  silc_sync_s n;

  always_comb
  begin
    n    = r;
    n.s1 = d;
    n.s2 = r.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '1;
    else if (ce)
      r <= n;
  end

  assign q = r.s2;
endmodule // silc_sync

//--- silc_periph.sv
// Peripheral end of the serial interrupt line: one request bit per data frame.
// Assumes the host makes the link clock; all link inputs are synchronised to pclk.
`timescale 1ns/10ps
`include "silc_defs.svh"

module silc_periph
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic [20:0] irq_n,
  output logic             quiet_mode,
  silc_if.dev              link
);
  import silc_pkg::*;

  silc_per_s  r;
  silc_per_s  n;
  logic [2:0] sy;
  logic       pend;

  silc_sync #(.W(3)) u_sync
  (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .d       ({link.lpc_clk, link.ser_line, link.clk_run_line}),
    .q       (sy)
  );

  // ----------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------
  // The line is sampled on the falling link edge, mid-clock, where it is stable;
  // drive changes are made on the rising link edge.
  always_comb
  begin
    n         = r;
    pend      = (irq_n != r.sent);
    n.lprev   = sy[2];
    n.cr_oe_n = ~(r.quiet & ~r.act & pend & sy[0]);
    if (!sy[2] && r.lprev && !r.act)
    begin
      if (!sy[1])
        n.run = (r.run == 4'hf) ? r.run : r.run + 4'h1;
      else
      begin
        if (r.run >= 4'(`SILC_START_MIN))
        begin
          n.act = 1'b1;
          n.ph  = PH_TURN;
          n.fr  = 5'h0;
        end
        else if (r.run == 4'(`SILC_STOP_QUIET))
          n.quiet = 1'b1;
        else if (r.run == 4'(`SILC_STOP_CONT))
          n.quiet = 1'b0;
        n.run = 4'h0;
      end
    end
    if (sy[2] && !r.lprev)
    begin
      n.o    = 1'b0;
      n.oe_n = 1'b1;
      if (r.act)
      begin
        case (r.ph)
          PH_TURN:
          begin
            if (r.fr == `SILC_NFRAMES)
              n.act = 1'b0;
            else
            begin
              n.ph         = PH_SAMPLE;
              n.fr         = r.fr + 5'h1;
              n.oe_n       = irq_n[r.fr];
              n.sent[r.fr] = irq_n[r.fr];
            end
          end
          PH_SAMPLE:
          begin
            n.ph   = PH_RECOV;
            n.o    = 1'b1;
            n.oe_n = r.oe_n;
          end
          default:
            n.ph = PH_TURN;
        endcase
      end
      else if (r.quiet && r.run == 4'h0 && sy[1] && pend)
        n.oe_n = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r         <= '0;
      r.lprev   <= 1'b1;
      r.oe_n    <= 1'b1;
      r.cr_oe_n <= 1'b1;
      r.sent    <= `SILC_DEC_IDLE;
    end
    else if (ce)
      r <= n;
  end

  assign quiet_mode             = r.quiet;
  assign link.ser_dev_o         = r.o;
  assign link.ser_dev_oe_n      = r.oe_n;
  assign link.clk_run_dev_o     = 1'b0;
  assign link.clk_run_dev_oe_n  = r.cr_oe_n;
endmodule // silc_periph

//--- silc_properties.sv
// Concurrent checks on the serial interrupt link between the host end and the peripheral end.
// Assumes it watches one silc_if instance, sampled on pclk, with presetn active low.
`timescale 1ns/10ps

module silc_properties
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lpc_clk,
  input wire logic ser_host_oe_n,
  input wire logic ser_dev_o,
  input wire logic ser_dev_oe_n,
  input wire logic ser_line,
  input wire logic clk_run_host_oe_n
);
  logic [7:0] low_cnt_reg;

  // Counts how long the host has held the line low, so frame widths can be judged at release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_cnt_reg <= 8'h00;
    else if (ser_host_oe_n)
      low_cnt_reg <= 8'h00;
    else
      low_cnt_reg <= low_cnt_reg + 8'h01;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Link clock and frames
  // ----------------------------------------------------------------
  property p_clk_high; $rose(lpc_clk) |-> lpc_clk [*4]; endproperty
  a_clk_high: assert property (p_clk_high)
    else $error("link clock high phase too short");
  property p_clk_low; $fell(lpc_clk) |-> !lpc_clk [*4]; endproperty
  a_clk_low: assert property (p_clk_low)
    else $error("link clock low phase too short");
  property p_host_width;
    $rose(ser_host_oe_n) |-> low_cnt_reg inside {8'h10, 8'h18, 8'h38, 8'h40};
  endproperty
  a_host_width: assert property (p_host_width)
    else $error("host start or stop frame has a wrong width");
  property p_after_host; $rose(ser_host_oe_n) |-> ser_line [*8]; endproperty
  a_after_host: assert property (p_after_host)
    else $error("line not released for one clock after a host frame");
  property p_dev_sample;
    $fell(ser_dev_oe_n) |-> !ser_dev_o [*8] ##1 (ser_dev_o || ser_dev_oe_n);
  endproperty
  a_dev_sample: assert property (p_dev_sample)
    else $error("peripheral low drive not exactly one link clock");
  property p_dev_recov;
    $rose(ser_dev_o) && !ser_dev_oe_n |-> ##1 (ser_dev_o && !ser_dev_oe_n) [*7] ##1 ser_dev_oe_n;
  endproperty
  a_dev_recov: assert property (p_dev_recov)
    else $error("peripheral recovery or turn-around malformed");
  property p_no_fight; !ser_host_oe_n |-> (ser_dev_oe_n || !ser_dev_o); endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("peripheral drives high while host drives low");
  property p_crun_quiet; $rose(clk_run_host_oe_n) |-> ser_host_oe_n && ser_line; endproperty
  a_crun_quiet: assert property (p_crun_quiet)
    else $error("clock stop requested while the serial line is busy");
endmodule // silc_properties

//--- tb_serial_irq_host_and_lpc_clock_ctl.sv
// Self-checking bench: host and peripheral joined by silc_if, host registers reached over APB.
// Assumes the design files and silc_properties.sv are compiled before this file.
`timescale 1ns/10ps
`include "silc_defs.svh"

module tb_serial_irq_host_and_lpc_clock_ctl;
  import silc_pkg::*;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] int_n;
  logic        chk_in_n;
  logic [3:0]  pcie_n;
  logic [20:0] irq_n;
  logic [15:0] isa_n;
  logic [3:0]  pci_n;
  logic        mgmt_n;
  logic        chk_n;
  logic        clk1;
  logic        quiet;
  logic        snap;
  logic [31:0] seed;
  logic [32:0] exp_q[$];
  int          errors;
  int          checks;

  silc_if silc_if_inst ();

  silc_host silc_host_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .deep_idle(1'b0), .internal_irq_n(int_n),
    .chan_chk_in_n(chk_in_n), .pcie_shared_irq_inputs(pcie_n), .loopback_select_strap(1'b0),
    .second_clock_enable_strap(1'b1), .isa_irq_n(isa_n), .pci_irq_n(pci_n),
    .sys_mgmt_interrupt_n(mgmt_n), .channel_check_error_n(chk_n), .lpc_clk1_out(clk1),
    .link(silc_if_inst.host));

  silc_periph silc_periph_inst (.pclk(pclk), .presetn(presetn), .ce(1'b1), .irq_n(irq_n),
    .quiet_mode(quiet), .link(silc_if_inst.dev));

  silc_properties silc_properties_inst (.pclk(pclk), .presetn(presetn),
    .lpc_clk(silc_if_inst.lpc_clk), .ser_host_oe_n(silc_if_inst.ser_host_oe_n),
    .ser_dev_o(silc_if_inst.ser_dev_o), .ser_dev_oe_n(silc_if_inst.ser_dev_oe_n),
    .ser_line(silc_if_inst.ser_line), .clk_run_host_oe_n(silc_if_inst.clk_run_host_oe_n));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // ----------------------------------------------------------------
  // Drivers and checking
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge keeps psel from being assigned twice in one time step.
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic chk_out(input logic [23:0] e);
    exp_q.push_back({9'h000, e});
    snap <= 1'b1;
    @(posedge pclk);
    snap <= 1'b0;
  endtask

  task automatic compare(input logic [32:0] got);
    logic [32:0] e;
    e = 33'bx;
    if (exp_q.size() > 0)
      e = exp_q.pop_front();
    checks++;
    if (got !== e)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite)
      compare({pslverr, prdata});
    else if (snap)
      compare({9'h000, quiet, clk1, chk_n, mgmt_n, pci_n, isa_n});
  end

  // Random levels on every source, then two full link cycles before judging the merge.
  task automatic run_case(input logic [4:0] ctrl);
    logic [31:0] r;
    logic [20:0] dec;
    r = xs();
    irq_n <= r[20:0];
    dec = r[20:0] | `SILC_IGNORE_MASK;
    r = xs();
    int_n    <= r[15:0];
    pcie_n   <= r[19:16];
    chk_in_n <= r[20];
    repeat (1400) @(posedge pclk);
    rd(`SILC_OFF_DEC, {12'h000, dec});
    chk_out({~ctrl[1], 1'b0, dec[16] & r[20], dec[2], r[19:16] & dec[20:17],
             r[15:0] & {dec[15:3], 1'b1, dec[1:0]}});
    // In continuous mode a full cycle follows the clear, so the flag shows frame 3 afresh.
    if (ctrl[1])
    begin
      apb(1'b1, `SILC_OFF_STAT, 32'h0000_0001);
      repeat (700) @(posedge pclk);
      rd(`SILC_OFF_STAT, {30'h0000_0000, 1'b1, 1'b0, ~dec[2]});
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge pclk);
    errors++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    final_report();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    seed = 32'ha293;
    presetn = 1'b0;
    {psel, penable, pwrite, snap} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    int_n = 16'hffff;
    chk_in_n = 1'b1;
    pcie_n = 4'hf;
    irq_n = 21'h1f_ffff;
    errors = 0;
    checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(`SILC_OFF_CTRL, {28'h000_0000, `SILC_CTRL_RST | 5'h10});
    rd(`SILC_OFF_STAT, 33'h0_0000_0010);
    rd(`SILC_OFF_DEC, {12'h000, `SILC_DEC_IDLE});
    rd(12'h00c, 33'h1_0000_0000);
    apb(1'b1, `SILC_OFF_CTRL, 32'h0000_000b);
    for (int i = 0; i < 3; i++)
      run_case(5'h0b);
    apb(1'b1, `SILC_OFF_CTRL, 32'h0000_0009);
    run_case(5'h09);
    apb(1'b1, `SILC_OFF_STAT, 32'h0000_0001);
    rd(`SILC_OFF_STAT, 33'h0_0000_0002);
    apb(1'b1, `SILC_OFF_CTRL, 32'h0000_000d);
    repeat (200) @(posedge pclk);
    rd(`SILC_OFF_STAT, 33'h0_0000_0022);
    for (int i = 0; i < 2; i++)
      run_case(5'h0d);
    apb(1'b1, `SILC_OFF_CTRL, 32'h0000_0008);
    repeat (1400) @(posedge pclk);
    rd(`SILC_OFF_DEC, {12'h000, `SILC_DEC_IDLE});
    final_report();
  end
endmodule // tb_serial_irq_host_and_lpc_clock_ctl
